// ===== hw/timer16_pkg.sv
// Constants and types for the 16-bit compare/waveform timer block.
// Assumes an APB master on the same clock and a prescaler tick input.
`default_nettype none
package timer16_pkg;
   localparam int unsigned CHANNELS = 2;
   localparam logic [7:0] CTRL_ADDR    = 8'h00;
   localparam logic [7:0] FORCE_ADDR   = 8'h04;
   localparam logic [7:0] CNT_LO_ADDR  = 8'h08;
   localparam logic [7:0] CNT_HI_ADDR  = 8'h0C;
   localparam logic [7:0] CMP_LO_ADDR [CHANNELS] = '{8'h10, 8'h18};
   localparam logic [7:0] CMP_HI_ADDR [CHANNELS] = '{8'h14, 8'h1C};
   localparam logic [7:0] CAPT_LO_ADDR = 8'h20;
   localparam logic [7:0] CAPT_HI_ADDR = 8'h24;
   localparam logic [7:0] MASK_ADDR    = 8'h28;
   localparam logic [7:0] FLAG_ADDR    = 8'h2C;
   localparam logic [7:0] PORT_ADDR    = 8'h30;
   // Flag and mask bit positions
   localparam int unsigned FLAG_OVF  = 0;
   localparam int unsigned FLAG_CMP0 = 1;
   localparam int unsigned FLAG_CAPT = 3;
   // Port register field positions
   localparam int unsigned PORT_OUT_LSB = 0;
   localparam int unsigned PORT_DIR_LSB = 2;
   // Waveform select codes
   localparam logic [3:0] WGM_NORMAL   = 4'h0;
   localparam logic [3:0] WGM_CLR_CMP  = 4'h4;
   localparam logic [3:0] WGM_CLR_CAPT = 4'hC;
   localparam logic [3:0] WGM_RESERVED = 4'hD;
   localparam logic [3:0] WGM_FAST_CAP = 4'hE;
   localparam logic [3:0] WGM_FAST_CMP = 4'hF;
   // Compare output actions
   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR  = 2'h2;
   localparam logic [1:0] ACT_SET    = 2'h3;
   localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [7:0]  CTRL_RESET = 8'h00;
   localparam logic [3:0]  MASK_RESET = 4'h0;
   localparam logic [3:0]  PORT_RESET = 4'h0;
   typedef struct packed {
      logic [1:0] act_b;
      logic [1:0] act_a;
      logic [3:0] wgm;
   } ctrl_s;
endpackage : timer16_pkg
`default_nettype wire

// ===== hw/timer16_compare_waveform.sv
// Compare-match and waveform unit of a 16-bit timer, APB register slave.
// Assumes tick_i and irq_ack_i come from logic on clock_i.
// How it works
// - Nonzero action field puts output state on pin instead of port value
// - Pin enable follows direction bit; software sets it to output first
// - Reset clears both output states to zero
// - Action zero leaves output state unchanged on match
// - New action value acts only at the next match, force strobe or PWM bottom
// - Force strobe applies action at once in non-PWM modes
// - Action fields never touch capture behaviour
// - Counter equal to active compare value sets match flag on tick
// - Enabled set flags raise interrupt; service or write-one clears
// - Channel A compare value sets counter limit in mode 4 only
// - PWM modes buffer compare values, loaded at bottom
// - Host reaches buffer when buffered, active register otherwise
// - Compare bytes read directly, not through the high byte latch
// - High byte to latch first; low write moves both at once
// - Counting ignores action bits; in PWM they pick polarity
// - Non-PWM actions: toggle, clear or set on match
// - Normal mode counts up and wraps from all ones to zero
// - Overflow flag set as counter wraps to zero; service or write-one clears
// - Counter writable at any time in normal mode
// - Modes 4 and 12 clear counter on channel A or capture match
// - Clear-on-match limit sets channel A flag or capture flag
// - Limit below count is missed; counter wraps first
// - Host counter write beats clear or increment
//
// Register access over APB and the address map were left to the implementer.
`default_nettype none
module timer16_compare_waveform (
   input  wire logic                                clock_i,
   input  wire logic                                nrst_i,
   input  wire logic                                tick_i,
   input  wire logic [3:0]                          irq_ack_i,
   input  wire logic                                psel_i,
   input  wire logic                                penable_i,
   input  wire logic                                pwrite_i,
   input  wire logic [7:0]                          paddr_i,
   input  wire logic [31:0]                         pwdata_i,
   output logic      [31:0]                         prdata_o,
   output logic                                     pready_o,
   output logic                                     pslverr_o,
   output logic                                     irq_o,
   output logic      [timer16_pkg::CHANNELS-1:0]    pin_o,
   output logic      [timer16_pkg::CHANNELS-1:0]    pin_oe_o
);
   import timer16_pkg::*;

   ctrl_s        ctrl;
   logic [15:0]  count;
   logic [15:0]  capt;
   logic [7:0]   hi_latch;
   logic [3:0]   flags;
   logic [3:0]   mask;
   logic [3:0]   port_reg;
   logic [15:0]  cmp_act  [CHANNELS];
   logic [15:0]  cmp_buf  [CHANNELS];
   logic [15:0]  cmp_view [CHANNELS];
   logic [1:0]   oc_state;
   logic [1:0]   act      [CHANNELS];
   logic [1:0]   match;
   logic [1:0]   force_wr;
   logic [1:0]   cmp_lo_wr;
   logic [1:0]   cmp_hi_wr;
   logic [3:0]   flag_set;
   logic [3:0]   flag_clr;
   logic [7:0]   rd_byte;
   logic         addr_ok;
   logic         setup;
   logic         wr_en;
   logic         rd_en;
   logic         pwm;
   logic         cnt_wr;
   logic         clear_hit;
   logic         bottom;

   function automatic logic is_pwm(input logic [3:0] wgm);
      is_pwm = !(wgm == WGM_NORMAL || wgm == WGM_CLR_CMP || wgm == WGM_CLR_CAPT || wgm == WGM_RESERVED);
   endfunction : is_pwm

   // Output state after a compare match or a forced match
   function automatic logic on_match(input logic [1:0] a, input logic st, input logic pw, input logic tog_ok);
      case (a)
         ACT_TOGGLE: on_match = (!pw || tog_ok) ? !st : st;
         ACT_CLEAR:  on_match = 1'b0;
         ACT_SET:    on_match = 1'b1;
         default:    on_match = st;
      endcase
   endfunction : on_match

   // Output state at bottom in PWM modes, opposite of the match level
   function automatic logic on_bottom(input logic [1:0] a, input logic st);
      case (a)
         ACT_CLEAR: on_bottom = 1'b1;
         ACT_SET:   on_bottom = 1'b0;
         default:   on_bottom = st;
      endcase
   endfunction : on_bottom

   assign setup = psel_i && !penable_i;
   assign wr_en = psel_i && penable_i && pready_o && pwrite_i;
   assign rd_en = psel_i && penable_i && pready_o && !pwrite_i;
   assign pwm = is_pwm(ctrl.wgm);
   assign act[0] = ctrl.act_a;
   assign act[1] = ctrl.act_b;
   assign cnt_wr = wr_en && paddr_i == CNT_LO_ADDR;
   assign bottom = tick_i && count == COUNT_ZERO;

   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         match[i] = count == cmp_act[i];
         cmp_view[i] = pwm ? cmp_buf[i] : cmp_act[i];
         cmp_lo_wr[i] = wr_en && paddr_i == CMP_LO_ADDR[i];
         cmp_hi_wr[i] = wr_en && paddr_i == CMP_HI_ADDR[i];
         force_wr[i] = wr_en && paddr_i == FORCE_ADDR && pwdata_i[i] && !pwm;
      end
   end

   // Limit comes from channel A or capture register; equality only, so a missed limit wraps
   assign clear_hit = (ctrl.wgm == WGM_CLR_CMP && match[0])
                    || (ctrl.wgm == WGM_CLR_CAPT && count == capt);

   // Register read mux
   always_comb begin
      rd_byte = 8'h00;
      addr_ok = 1'b1;
      case (paddr_i)
         CTRL_ADDR:      rd_byte = ctrl;
         FORCE_ADDR:     rd_byte = 8'h00;
         CNT_LO_ADDR:    rd_byte = count[7:0];
         CNT_HI_ADDR:    rd_byte = hi_latch;
         CMP_LO_ADDR[0]: rd_byte = cmp_view[0][7:0];
         CMP_HI_ADDR[0]: rd_byte = cmp_view[0][15:8];
         CMP_LO_ADDR[1]: rd_byte = cmp_view[1][7:0];
         CMP_HI_ADDR[1]: rd_byte = cmp_view[1][15:8];
         CAPT_LO_ADDR:   rd_byte = capt[7:0];
         CAPT_HI_ADDR:   rd_byte = hi_latch;
         MASK_ADDR:      rd_byte = {4'h0, mask};
         FLAG_ADDR:      rd_byte = {4'h0, flags};
         PORT_ADDR:      rd_byte = {4'h0, port_reg};
         default:        addr_ok = 1'b0;
      endcase
   end

   // APB answer: ready in the first access cycle
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o <= setup;
         if (setup) begin
            pslverr_o <= !addr_ok;
            prdata_o  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         end
      end
   end

   // Control, mask and port registers
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl     <= ctrl_s'(CTRL_RESET);
         mask     <= MASK_RESET;
         port_reg <= PORT_RESET;
      end else if (wr_en) begin
         if (paddr_i == CTRL_ADDR) begin
            ctrl <= ctrl_s'(pwdata_i[7:0]);
         end
         if (paddr_i == MASK_ADDR) begin
            mask <= pwdata_i[3:0];
         end
         if (paddr_i == PORT_ADDR) begin
            port_reg <= pwdata_i[3:0];
         end
      end
   end

   // Shared high byte latch
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hi_latch <= 8'h00;
      end else if (wr_en && (paddr_i == CNT_HI_ADDR || paddr_i == CAPT_HI_ADDR || |cmp_hi_wr)) begin
         hi_latch <= pwdata_i[7:0];
      end else if (rd_en && paddr_i == CNT_LO_ADDR) begin
         hi_latch <= count[15:8];
      end else if (rd_en && paddr_i == CAPT_LO_ADDR) begin
         hi_latch <= capt[15:8];
      end
   end

   // Counter
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count <= COUNT_ZERO;
      end else if (cnt_wr) begin
         count <= {hi_latch, pwdata_i[7:0]};
      end else if (tick_i) begin
         if (clear_hit) begin
            count <= COUNT_ZERO;
         end else begin
            count <= count + 16'h0001;
         end
      end
   end

   // Capture register, host-written only in modes 12 and 14
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         capt <= COUNT_ZERO;
      end else if (wr_en && paddr_i == CAPT_LO_ADDR
                   && (ctrl.wgm == WGM_CLR_CAPT || ctrl.wgm == WGM_FAST_CAP)) begin
         capt <= {hi_latch, pwdata_i[7:0]};
      end
   end

   // Compare values, buffered in PWM modes
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < CHANNELS; i++) begin
            cmp_act[i] <= COUNT_ZERO;
            cmp_buf[i] <= COUNT_ZERO;
         end
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (cmp_lo_wr[i] && pwm) begin
               cmp_buf[i] <= {hi_latch, pwdata_i[7:0]};
            end
            if (cmp_lo_wr[i] && !pwm) begin
               cmp_act[i] <= {hi_latch, pwdata_i[7:0]};
            end else if (pwm && bottom) begin
               cmp_act[i] <= cmp_buf[i];
            end
         end
      end
   end

   // Flags: set wins over clear
   always_comb begin
      flag_set = 4'h0;
      flag_set[FLAG_OVF] = tick_i && !cnt_wr && count == COUNT_MAX;
      for (int i = 0; i < CHANNELS; i++) begin
         flag_set[FLAG_CMP0 + i] = tick_i && match[i];
      end
      flag_set[FLAG_CAPT] = tick_i && ctrl.wgm == WGM_CLR_CAPT && count == capt;
      flag_clr = irq_ack_i | ((wr_en && paddr_i == FLAG_ADDR) ? pwdata_i[3:0] : 4'h0);
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flags <= 4'h0;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(flags & mask);
      end
   end

   // Output states; force takes precedence over a match in the same cycle
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         oc_state <= 2'b00;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (force_wr[i]) begin
               oc_state[i] <= on_match(act[i], oc_state[i], 1'b0, 1'b0);
            end else if (tick_i && match[i]) begin
               oc_state[i] <= on_match(act[i], oc_state[i], pwm,
                                       i == 0 && ctrl.wgm == WGM_FAST_CMP);
            end else if (pwm && bottom) begin
               oc_state[i] <= on_bottom(act[i], oc_state[i]);
            end
         end
      end
   end

   // Pin drive
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_o    <= 2'b00;
         pin_oe_o <= 2'b00;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            pin_o[i]    <= (act[i] != ACT_NONE) ? oc_state[i] : port_reg[PORT_OUT_LSB + i];
            pin_oe_o[i] <= port_reg[PORT_DIR_LSB + i];
         end
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   property p_pin_override;
      ctrl.act_a != ACT_NONE |=> pin_o[0] == $past(oc_state[0]);
   endproperty
   a_pin_override: assert property (p_pin_override) else $error("pin A not overridden");

   property p_pin_dir;
      port_reg[PORT_DIR_LSB + 1] |=> pin_oe_o[1];
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("pin B enable ignores direction");

   property p_no_action;
      tick_i && match[0] && ctrl.act_a == ACT_NONE && !force_wr[0] |=> $stable(oc_state[0]);
   endproperty
   a_no_action: assert property (p_no_action) else $error("action zero changed state");

   property p_force_set;
      force_wr[1] && ctrl.act_b == ACT_SET |=> oc_state[1] ##1 pin_o[1];
   endproperty
   a_force_set: assert property (p_force_set) else $error("force did not set state");

   property p_match_flag;
      tick_i && match[1] |=> flags[FLAG_CMP0 + 1];
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("match flag not set");

   property p_overflow;
      tick_i && !cnt_wr && count == COUNT_MAX |=> flags[FLAG_OVF] && count == COUNT_ZERO;
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow not flagged at wrap");

   property p_limit_clear;
      tick_i && !cnt_wr && ctrl.wgm == WGM_CLR_CMP && match[0] |=> count == COUNT_ZERO;
   endproperty
   a_limit_clear: assert property (p_limit_clear) else $error("counter not cleared on limit");

   property p_buffered;
      cmp_lo_wr[0] && pwm && !bottom |=> $stable(cmp_act[0]);
   endproperty
   a_buffered: assert property (p_buffered) else $error("buffered write hit active value");

   property p_cnt_write;
      cnt_wr |=> count == $past({hi_latch, pwdata_i[7:0]});
   endproperty
   a_cnt_write: assert property (p_cnt_write) else $error("counter write lost");

   property p_tick_only;
      !tick_i && !cnt_wr |=> $stable(count);
   endproperty
   a_tick_only: assert property (p_tick_only) else $error("counter moved without tick");

   property p_irq;
      (flags & mask) != 4'h0 |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_force_pwm;
      wr_en && paddr_i == FORCE_ADDR && pwm && !tick_i |=> $stable(oc_state);
   endproperty
   a_force_pwm: assert property (p_force_pwm) else $error("force acted in PWM mode");

   property p_capt_clear;
      tick_i && !cnt_wr && ctrl.wgm == WGM_CLR_CAPT && count == capt |=> count == COUNT_ZERO && flags[FLAG_CAPT];
   endproperty
   a_capt_clear: assert property (p_capt_clear) else $error("capture limit not applied");

   property p_flag_ack;
      irq_ack_i[FLAG_OVF] && !flag_set[FLAG_OVF] |=> !flags[FLAG_OVF];
   endproperty
   a_flag_ack: assert property (p_flag_ack) else $error("serviced flag not cleared");

   property p_buffer_load;
      pwm && bottom && !cmp_lo_wr[1] |=> cmp_act[1] == $past(cmp_buf[1]);
   endproperty
   a_buffer_load: assert property (p_buffer_load) else $error("buffer not loaded at bottom");
endmodule : timer16_compare_waveform
`default_nettype wire

// ===== dv/timer16_host_model.sv
// APB host model standing in for the processor core.
// Assumes one clock; transfers are started by task calls from the bench.
`default_nettype none
module timer16_host_model (
   input  wire logic        clock_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i,
   input  wire logic [31:0] prdata_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [7:0]       paddr_o,
   output logic [31:0]      pwdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      psel_o    = 1'b0;
      penable_o = 1'b0;
      pwrite_o  = 1'b0;
      paddr_o   = 8'h00;
      pwdata_o  = 32'h0000_0000;
   end
   // Setup, then access held until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err, output bit hung);
      int n;
      n = 0;
      @(posedge clock_i);
      psel_o    <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o  <= wr;
      paddr_o   <= a;
      pwdata_o  <= wd;
      @(posedge clock_i);
      penable_o <= 1'b1;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready_i !== 1'b1 && n < 16);
      hung = (pready_i !== 1'b1);
      rd = prdata_i;
      err = pslverr_i;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
   endtask : xfer
endmodule : timer16_host_model
`default_nettype wire

// ===== dv/test_timer16_compare_waveform.sv
// Self-checking bench for the timer compare and waveform block.
// Assumes the package, the design and the host model are compiled first.
`default_nettype none
module test_timer16_compare_waveform;
   timeunit 1ns;
   timeprecision 1ns;
   import timer16_pkg::*;
   logic        clock_i   = 1'b0;
   logic        nrst_i    = 1'b0;
   logic        tick_i    = 1'b0;
   logic [3:0]  irq_ack_i = 4'h0;
   logic        psel, penable, pwrite, pready, pslverr, irq_o;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0]  pin_o, pin_oe_o;
   int          error_cnt   = 0;
   int          check_count = 0;
   always #25 clock_i = ~clock_i;
   timer16_host_model u_host (.clock_i(clock_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
      .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
   timer16_compare_waveform u_timer16_compare_waveform (.clock_i(clock_i), .nrst_i(nrst_i), .tick_i(tick_i),
      .irq_ack_i(irq_ack_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq_o),
      .pin_o(pin_o), .pin_oe_o(pin_oe_o));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t ns: pins %h expected %h", $time, got, exp);
      end
   endtask : chk_pin
   // Read compares against v; write sends v
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] v, input logic err_exp);
      logic [31:0] d;
      logic        e;
      bit          h;
      u_host.xfer(wr, a, v, d, e, h);
      if (h) begin
         error_cnt++;
         end_of_test();
      end
      if (!wr) chk(d, v);
      chk({31'h0, e}, {31'h0, err_exp});
   endtask : acc
   task automatic w16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
      acc(1'b1, hi, {24'h0, v[15:8]}, 1'b0);
      acc(1'b1, lo, {24'h0, v[7:0]}, 1'b0);
   endtask : w16
   task automatic r16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
      acc(1'b0, lo, {24'h0, v[7:0]}, 1'b0);
      acc(1'b0, hi, {24'h0, v[15:8]}, 1'b0);
   endtask : r16
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clock_i);
         tick_i <= 1'b1;
         @(posedge clock_i);
         tick_i <= 1'b0;
      end
   endtask : ticks
   task automatic t_reset_map();
      acc(1'b0, CTRL_ADDR, 32'h0, 1'b0);
      acc(1'b0, FLAG_ADDR, 32'h0, 1'b0);
      acc(1'b1, 8'hFC, 32'h5A, 1'b1);
      acc(1'b0, 8'hFC, 32'h0, 1'b1);
      $display("test reset_map done");
   endtask : t_reset_map
   task automatic t_pins();
      logic [7:0] ctl [4];
      logic [1:0] pe [4];
      ctl = '{8'h10, 8'h10, 8'h20, 8'h30};
      pe = '{2'b01, 2'b00, 2'b00, 2'b01};
      acc(1'b1, PORT_ADDR, 32'h1, 1'b0);
      repeat (2) @(posedge clock_i);
      chk_pin(pin_oe_o, 2'b00);
      acc(1'b1, PORT_ADDR, 32'hD, 1'b0);
      repeat (2) @(posedge clock_i);
      chk_pin(pin_o, 2'b01);
      chk_pin(pin_oe_o, 2'b11);
      acc(1'b1, CTRL_ADDR, 32'h10, 1'b0);
      repeat (2) @(posedge clock_i);
      chk_pin(pin_o, 2'b00);
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, CTRL_ADDR, {24'h0, ctl[i]}, 1'b0);
         acc(1'b1, FORCE_ADDR, 32'h1, 1'b0);
         repeat (2) @(posedge clock_i);
         chk_pin(pin_o, pe[i]);
      end
      $display("test pins done");
   endtask : t_pins
   task automatic t_cmp_rw();
      w16(CMP_LO_ADDR[0], CMP_HI_ADDR[0], 16'h1234);
      w16(CNT_LO_ADDR, CNT_HI_ADDR, 16'hABCD);
      acc(1'b0, CNT_LO_ADDR, 32'hCD, 1'b0);
      r16(CMP_LO_ADDR[0], CMP_HI_ADDR[0], 16'h1234);
      acc(1'b0, CNT_HI_ADDR, 32'hAB, 1'b0);
      $display("test cmp_rw done");
   endtask : t_cmp_rw
   task automatic t_normal();
      acc(1'b1, CTRL_ADDR, 32'h0, 1'b0);
      acc(1'b1, MASK_ADDR, 32'h1, 1'b0);
      @(posedge clock_i);
      tick_i <= 1'b1;
      w16(CNT_LO_ADDR, CNT_HI_ADDR, 16'hFFFE);
      tick_i <= 1'b0;
      acc(1'b1, FLAG_ADDR, 32'hF, 1'b0);
      r16(CNT_LO_ADDR, CNT_HI_ADDR, 16'hFFFE);
      ticks(1);
      acc(1'b0, FLAG_ADDR, 32'h0, 1'b0);
      ticks(1);
      r16(CNT_LO_ADDR, CNT_HI_ADDR, 16'h0000);
      acc(1'b0, FLAG_ADDR, 32'h1, 1'b0);
      chk_pin({1'b0, irq_o}, 2'b01);
      @(posedge clock_i);
      irq_ack_i <= 4'h1;
      @(posedge clock_i);
      irq_ack_i <= 4'h0;
      repeat (2) @(posedge clock_i);
      chk_pin({1'b0, irq_o}, 2'b00);
      acc(1'b0, FLAG_ADDR, 32'h0, 1'b0);
      acc(1'b1, MASK_ADDR, 32'h0, 1'b0);
      $display("test normal done");
   endtask : t_normal
   task automatic t_clear_match();
      w16(CMP_LO_ADDR[0], CMP_HI_ADDR[0], 16'h0003);
      w16(CMP_LO_ADDR[1], CMP_HI_ADDR[1], 16'h0002);
      w16(CNT_LO_ADDR, CNT_HI_ADDR, 16'h0000);
      acc(1'b1, CTRL_ADDR, 32'h14, 1'b0);
      acc(1'b1, FLAG_ADDR, 32'hF, 1'b0);
      ticks(3);
      r16(CNT_LO_ADDR, CNT_HI_ADDR, 16'h0003);
      acc(1'b0, FLAG_ADDR, 32'h4, 1'b0);
      chk_pin(pin_o, 2'b01);
      ticks(1);
      r16(CNT_LO_ADDR, CNT_HI_ADDR, 16'h0000);
      acc(1'b0, FLAG_ADDR, 32'h6, 1'b0);
      repeat (2) @(posedge clock_i);
      chk_pin(pin_o, 2'b00);
      w16(CNT_LO_ADDR, CNT_HI_ADDR, 16'h0005);
      ticks(1);
      r16(CNT_LO_ADDR, CNT_HI_ADDR, 16'h0006);
      $display("test clear_match done");
   endtask : t_clear_match
   task automatic t_buffer();
      acc(1'b1, CTRL_ADDR, 32'hCF, 1'b0);
      acc(1'b1, FORCE_ADDR, 32'h2, 1'b0);
      repeat (2) @(posedge clock_i);
      chk_pin(pin_o, 2'b01);
      w16(CNT_LO_ADDR, CNT_HI_ADDR, 16'h0100);
      w16(CMP_LO_ADDR[1], CMP_HI_ADDR[1], 16'h0101);
      acc(1'b1, FLAG_ADDR, 32'hF, 1'b0);
      ticks(2);
      acc(1'b0, FLAG_ADDR, 32'h0, 1'b0);
      r16(CMP_LO_ADDR[1], CMP_HI_ADDR[1], 16'h0101);
      w16(CNT_LO_ADDR, CNT_HI_ADDR, 16'h0000);
      ticks(1);
      w16(CNT_LO_ADDR, CNT_HI_ADDR, 16'h0101);
      acc(1'b1, FLAG_ADDR, 32'hF, 1'b0);
      ticks(1);
      acc(1'b0, FLAG_ADDR, 32'h4, 1'b0);
      chk_pin(pin_o, 2'b11);
      $display("test buffer done");
   endtask : t_buffer
   task automatic t_capture();
      @(posedge clock_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      acc(1'b1, CTRL_ADDR, 32'hC0, 1'b0);
      repeat (2) @(posedge clock_i);
      chk_pin(pin_o, 2'b00);
      acc(1'b1, CTRL_ADDR, 32'h0C, 1'b0);
      w16(CAPT_LO_ADDR, CAPT_HI_ADDR, 16'h0002);
      ticks(2);
      acc(1'b1, FLAG_ADDR, 32'hF, 1'b0);
      ticks(1);
      r16(CNT_LO_ADDR, CNT_HI_ADDR, 16'h0000);
      acc(1'b0, FLAG_ADDR, 32'h8, 1'b0);
      acc(1'b1, CTRL_ADDR, 32'h0, 1'b0);
      w16(CAPT_LO_ADDR, CAPT_HI_ADDR, 16'h0007);
      r16(CAPT_LO_ADDR, CAPT_HI_ADDR, 16'h0002);
      $display("test capture done");
   endtask : t_capture
   initial begin
      repeat (4) @(posedge clock_i);
      nrst_i <= 1'b1;
      t_reset_map();
      t_pins();
      t_cmp_rw();
      t_normal();
      t_clear_match();
      t_buffer();
      t_capture();
      end_of_test();
   end
endmodule : test_timer16_compare_waveform
`default_nettype wire
